/* File: src/osc_pkg.sv */
// Package of register offsets, field positions and constants for the block.
`default_nettype none
package osc_pkg;
    localparam logic [7:0] AddrIntFlags2   = 8'h01;
    localparam logic [7:0] AddrIntEn2      = 8'h02;
    localparam logic [7:0] AddrSyncTag     = 8'h10;
    localparam logic [7:0] AddrConvSetup1  = 8'h11;
    localparam logic [7:0] AddrConvSetup2  = 8'h12;
    localparam logic [7:0] AddrPresThresh  = 8'h14;
    localparam logic [7:0] AddrFilterCfg   = 8'h16;
    localparam logic [7:0] AddrPresLed     = 8'h29;
    localparam logic [7:0] AddrCalCtrl     = 8'h50;
    localparam logic [7:0] AddrSlotSel12   = 8'h20;
    localparam logic [7:0] AddrNormLed     = 8'h23;
    // Field positions.
    localparam int PresIntBit    = 4;
    localparam int TagEnBit      = 4;
    localparam int FiltEnBit     = 7;
    localparam int FiltOrderBit  = 6;
    localparam int CalStartBit   = 0;
    localparam int CalDoneBit    = 1;
    localparam int CalOorBit     = 2;
    localparam int RateLsb       = 3;
    // Conversion widths.
    localparam int AdcBits       = 16;
    localparam int DacBits       = 5;
    localparam int SampleBits    = 19;
    localparam int ThreshShift   = 11;
    localparam logic [3:0] TagNormal    = 4'h1;
    localparam logic [4:0] TagDacChange = 5'h1d;
    localparam logic [4:0] RateProximity = 5'h1f;
    // Calibration length in cycles at the core clock.
    localparam int CalCycles     = 1000;
    localparam logic [7:0] ResetZero = 8'h00;

    typedef struct packed {
        logic [SampleBits-1:0] data;
        logic [4:0]            tag;
    } osc_sample_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } osc_bus_t;
endpackage : osc_pkg
`default_nettype wire

/* File: src/osc_outlier_filter.sv */
// Outlier detect-and-replace filter with IIR error tracker.
`default_nettype none
module osc_outlier_filter
    import osc_pkg::*;
(
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Configuration.
    input  wire logic [7:0]            cfg,
    // Sample stream.
    input  wire logic                  inValid,
    input  wire logic [SampleBits-1:0] inData,
    output logic                       outValid,
    output logic [SampleBits-1:0]      outData,
    output logic                       outlier
);
    logic [SampleBits-1:0] hist_q [4];
    logic [SampleBits+5:0] lpf_q;
    logic                  primed_q;
    logic signed [SampleBits+2:0] pred;
    logic [SampleBits-1:0] predU;
    logic [SampleBits-1:0] diff;
    logic [SampleBits+5:0] thresh;
    logic [SampleBits+5:0] lpfNext;
    logic [2:0]            tcShift;
    logic [SampleBits+5:0] initVal;

    // Prediction: previous point, or line fit over four outputs.
    always_comb begin
        pred = $signed({3'b000, hist_q[0]}) +
               (($signed({3'b000, hist_q[1]}) -
                 $signed({3'b000, hist_q[3]})) >>> 1); // [RL23]
        if (!cfg[FiltOrderBit]) begin
            predU = hist_q[0]; // [RL17]
        end else if (pred < 0) begin
            predU = '0;
        end else if (pred > $signed({3'b000, {SampleBits{1'b1}}})) begin
            predU = {SampleBits{1'b1}};
        end else begin
            predU = pred[SampleBits-1:0]; // [RL17]
        end
        diff = (inData > predU) ? inData - predU : predU - inData; // [RL16]
        thresh = lpf_q << (3'd2 + {1'b0, cfg[1:0]}); // [RL18]
        tcShift = 3'd3 + {1'b0, cfg[5:4]}; // [RL19]
        lpfNext = lpf_q - (lpf_q >> tcShift) +
                  ({6'h00, diff} >> tcShift); // [RL24]
        initVal = {6'h00, 8'h00, cfg[3:2], 9'h000}; // [RL19]
    end

    // Tracker state; the first sample primes history and loads the lowpass init value.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !cfg[FiltEnBit]) begin
            primed_q <= 1'b0;
            lpf_q    <= '0;
            for (int i = 0; i < 4; i++) begin
                hist_q[i] <= '0;
            end
        end else if (inValid) begin
            primed_q <= 1'b1;
            lpf_q <= primed_q ? lpfNext : initVal; // [RL19]
            hist_q[1] <= hist_q[0];
            hist_q[2] <= hist_q[1];
            hist_q[3] <= hist_q[2];
            hist_q[0] <= (primed_q && {6'h00, diff} > thresh) ?
                         predU : inData;
        end
    end

    // Registered output: replace the point when the error is too big.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            outValid <= 1'b0;
            outData  <= '0;
            outlier  <= 1'b0;
        end else begin
            outValid <= inValid;
            if (inValid) begin
                if (cfg[FiltEnBit] && primed_q &&
                    {6'h00, diff} > thresh) begin // [RL15] [RL16]
                    outData <= predU; // [RL20]
                    outlier <= 1'b1;
                end else begin
                    outData <= inData; // [RL20]
                    outlier <= 1'b0;
                end
            end
        end
    end
endmodule : osc_outlier_filter
`default_nettype wire

/* File: src/osc_sample_conditioning.sv */
// Top of the optical sample-conditioning logic and its registers.
`default_nettype none
// Summary of operation
// [RL1]: Result joins 16-bit converter and 5-bit DAC.
// [RL2]: Host zeroes setup registers before calibration.
// [RL3]: Host sets range, time, then calibration start.
// [RL4]: Host waits, then polls calibration done.
// [RL5]: Done flag and out-of-range bit reported.
// [RL6]: Host writes slot register last to start.
// [RL7]: Tag enable marks DAC-change conversions 0x1d.
// [RL8]: Presence enabled by enable, threshold, pilot.
// [RL9]: Below threshold enters presence, sets flag.
// [RL10]: Presence uses pilot current, slow rate.
// [RL11]: Above threshold flags and restores normal.
// [RL12]: Presence skips slots two to six.
// [RL13]: Threshold counts in 2048-LSB steps.
// [RL14]: Host keeps pilot well below normal.
// [RL15]: Filter enable bit, clear after reset.
// [RL16]: Error above threshold flags outlier.
// [RL17]: Order bit picks previous or fit.
// [RL18]: Threshold is lowpass times 4..32.
// [RL19]: Time constant and init value selectable.
// [RL20]: Outlier replaced by prediction, else pass.
// [RL21]: Host sets multiplier to 32x.
// [RL22]: Slot fields choose exposure; first for presence.
// [RL23]: Fit is previous plus half step difference.
// [RL24]: Lowpass is first-order exponential average.
module osc_sample_conditioning
    import osc_pkg::*;
#(
    parameter int CalLength = CalCycles
)(
    // Clock and reset.
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    // Register port.
    input  wire logic [7:0]           regAddr,
    input  wire logic [7:0]           regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic [7:0]                regRdata,
    // Converter results from the analog side.
    input  wire logic                 convValid,
    input  wire logic [AdcBits-1:0]   convAdc,
    input  wire logic [DacBits-1:0]   convDac,
    input  wire logic [3:0]           convSlot,
    input  wire logic                 convOnPdOne,
    input  wire logic                 extMuxUsed,
    input  wire logic                 calOutOfRangeIn,
    // Conditioned output stream.
    output logic                      sampleValid,
    output osc_sample_t               sampleOut,
    // Control back to the sequencer.
    output logic                      presenceMode,
    output logic [7:0]                slotLedCurrent,
    output logic [4:0]                activeRate,
    output logic                      lowPowerMode,
    output logic                      slotSkipMask,
    output logic                      sequenceStart,
    output logic                      calRunning
);
    logic [7:0] intEn_q;
    logic [7:0] syncTag_q;
    logic [7:0] conv1_q;
    logic [7:0] conv2_q;
    logic [7:0] thresh_q;
    logic [7:0] filtCfg_q;
    logic [7:0] pilot_q;
    logic [7:0] slotSel_q;
    logic [7:0] normLed_q;
    logic       presFlag_q;
    logic       calDone_q;
    logic       calOor_q;
    logic       calBusy_q;
    logic [$clog2(CalLength+1)-1:0] calCnt_q;
    logic       pres_q;
    logic [DacBits-1:0] lastDac_q;
    logic       dacSeen_q;
    logic [SampleBits-1:0] rawSample;
    logic       firstSlot;
    logic       presElig;
    logic       below;
    logic       fOutValid;
    logic [SampleBits-1:0] fOutData;
    logic       dacChange_q;
    logic       dacChangeD;
    logic       hitEvent;

    // Combine coarse DAC and fine converter; two overlapping bits.
    always_comb begin
        rawSample = {convDac, 14'h0000} + {3'b000, convAdc}; // [RL1]
        firstSlot = (convSlot == slotSel_q[3:0]); // [RL22]
        presElig  = intEn_q[PresIntBit] && firstSlot &&
                    convOnPdOne && !extMuxUsed; // [RL8] [RL12]
        below     = rawSample < {thresh_q, 11'h000}; // [RL13]
        dacChangeD = dacSeen_q && (convDac != lastDac_q);
        hitEvent  = convValid && presElig && (pres_q ? !below : below);
    end

    // Register writes; each register its own concern.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            intEn_q   <= ResetZero;
            syncTag_q <= ResetZero;
            conv1_q   <= ResetZero;
            conv2_q   <= ResetZero;
            thresh_q  <= ResetZero;
            filtCfg_q <= ResetZero; // [RL15]
            pilot_q   <= ResetZero;
            slotSel_q <= ResetZero;
            normLed_q <= ResetZero;
        end else if (regWr) begin
            unique case (regAddr)
                AddrIntEn2:     intEn_q   <= regWdata;
                AddrSyncTag:    syncTag_q <= regWdata;
                AddrConvSetup1: conv1_q   <= regWdata;
                AddrConvSetup2: conv2_q   <= regWdata;
                AddrPresThresh: thresh_q  <= regWdata;
                AddrFilterCfg:  filtCfg_q <= regWdata;
                AddrPresLed:    pilot_q   <= regWdata;
                AddrSlotSel12:  slotSel_q <= regWdata;
                AddrNormLed:    normLed_q <= regWdata;
                default: ;
            endcase
        end
    end

    // Writing the slot register last starts measurement.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sequenceStart <= 1'b0;
        end else begin
            sequenceStart <= regWr && regAddr == AddrSlotSel12;
        end
    end

    // Self-calibration timer; done and out-of-range flags.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            calBusy_q <= 1'b0;
            calDone_q <= 1'b0;
            calOor_q  <= 1'b0;
            calCnt_q  <= '0;
        end else if (regWr && regAddr == AddrCalCtrl &&
                     regWdata[CalStartBit] && !calBusy_q) begin
            calBusy_q <= 1'b1;
            calDone_q <= 1'b0;
            calOor_q  <= 1'b0;
            calCnt_q  <= '0;
        end else if (calBusy_q) begin
            if (calCnt_q == ($clog2(CalLength+1))'(CalLength - 1)) begin
                calBusy_q <= 1'b0;
                calDone_q <= 1'b1; // [RL5]
                calOor_q  <= calOutOfRangeIn; // [RL5]
            end else begin
                calCnt_q <= calCnt_q + 1'b1;
            end
        end
    end

    // Presence state; a hit sets the sticky flag, read clears it.
    // The set wins over a clearing read in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pres_q     <= 1'b0;
            presFlag_q <= 1'b0;
        end else begin
            if (!intEn_q[PresIntBit]) begin
                pres_q <= 1'b0;
            end else if (hitEvent) begin
                pres_q <= !pres_q; // [RL9] [RL11]
            end
            if (hitEvent) begin
                presFlag_q <= 1'b1; // [RL9] [RL11]
            end else if (regRd && regAddr == AddrIntFlags2) begin
                presFlag_q <= 1'b0;
            end
        end
    end

    // Sub-DAC change tracking for the tag.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lastDac_q   <= '0;
            dacSeen_q   <= 1'b0;
            dacChange_q <= 1'b0;
        end else if (convValid) begin
            lastDac_q   <= convDac;
            dacSeen_q   <= 1'b1;
            dacChange_q <= dacChangeD;
        end
    end

    osc_outlier_filter u_filter (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .cfg      (filtCfg_q),
        .inValid  (convValid),
        .inData   (rawSample),
        .outValid (fOutValid),
        .outData  (fOutData),
        .outlier  ()
    );

    // Output stream with tag; change tag overrides the normal one.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sampleValid <= 1'b0;
            sampleOut   <= '0;
        end else begin
            sampleValid <= fOutValid;
            if (fOutValid) begin
                sampleOut.data <= fOutData;
                sampleOut.tag  <= (syncTag_q[TagEnBit] && dacChange_q) ?
                                  TagDacChange : {1'b0, TagNormal}; // [RL7]
            end
        end
    end

    // Sequencer controls follow presence mode; calRunning follows the calibration timer.
    always_comb begin
        presenceMode   = pres_q;
        slotLedCurrent = pres_q ? pilot_q : normLed_q; // [RL10] [RL11]
        activeRate     = pres_q ? RateProximity
                                : conv2_q[RateLsb +: 5]; // [RL10] [RL11]
        lowPowerMode   = pres_q; // [RL10]
        slotSkipMask   = pres_q; // [RL12]
        calRunning     = calBusy_q;
    end

    // Read data, one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regRdata <= ResetZero;
        end else if (regRd) begin
            unique case (regAddr)
                AddrIntFlags2:  regRdata <= {3'b000, presFlag_q, 4'h0};
                AddrIntEn2:     regRdata <= intEn_q;
                AddrSyncTag:    regRdata <= syncTag_q;
                AddrConvSetup1: regRdata <= conv1_q;
                AddrConvSetup2: regRdata <= conv2_q;
                AddrPresThresh: regRdata <= thresh_q;
                AddrFilterCfg:  regRdata <= filtCfg_q;
                AddrPresLed:    regRdata <= pilot_q;
                AddrSlotSel12:  regRdata <= slotSel_q;
                AddrNormLed:    regRdata <= normLed_q;
                AddrCalCtrl:    regRdata <= {5'h00, calOor_q, calDone_q,
                                             calBusy_q};
                default:        regRdata <= ResetZero;
            endcase
        end else begin
            regRdata <= ResetZero;
        end
    end
endmodule : osc_sample_conditioning
`default_nettype wire

/* File: tb/osc_sample_conditioning_properties.sv */
// Checker of the conditioning block's port behaviour.
`default_nettype none
module osc_sample_conditioning_properties
    import osc_pkg::*;
#(
    parameter int CalLength = CalCycles
)(
    // Clock, reset and register port.
    input wire logic                 ref_clk,
    input wire logic                 sys_rst,
    input wire logic [7:0]           regAddr,
    input wire logic [7:0]           regWdata,
    input wire logic                 regWr,
    input wire logic                 regRd,
    input wire logic [7:0]           regRdata,
    // Converter side.
    input wire logic                 convValid,
    input wire logic [AdcBits-1:0]   convAdc,
    input wire logic [DacBits-1:0]   convDac,
    // Outputs watched.
    input wire logic                 sampleValid,
    input wire osc_sample_t          sampleOut,
    input wire logic                 presenceMode,
    input wire logic [4:0]           activeRate,
    input wire logic                 lowPowerMode,
    input wire logic                 slotSkipMask,
    input wire logic                 sequenceStart,
    input wire logic                 calRunning
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Margin past the nominal length covers the start and end edges.
    localparam int CalMax = CalLength + 3;
    logic                  tagEn_q;
    logic                  filtEn_q;
    logic                  seen_q;
    logic [DacBits-1:0]    lastDac_q;
    logic [SampleBits-1:0] rawNow;
    assign rawNow = {convDac, 14'h0} + SampleBits'(convAdc);
    // Shadow of the control bits the stream depends on.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tagEn_q  <= 1'b0;
            filtEn_q <= 1'b0;
        end else if (regWr && regAddr == AddrSyncTag) begin
            tagEn_q <= regWdata[TagEnBit];
        end else if (regWr && regAddr == AddrFilterCfg) begin
            filtEn_q <= regWdata[FiltEnBit];
        end
    end
    // Converter code of the previous conversion.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            seen_q    <= 1'b0;
            lastDac_q <= '0;
        end else if (convValid) begin
            seen_q    <= 1'b1;
            lastDac_q <= convDac;
        end
    end
    sequence calRequest;
        regWr && regAddr == AddrCalCtrl && regWdata[CalStartBit]
        && !calRunning;
    endsequence
    sequence calBusy;
        calRunning [*8];
    endsequence
    a_read_data_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_seq_start_pulse: assert property (
        sequenceStart == ($past(regWr) && $past(regAddr) == AddrSlotSel12
        && !$past(sys_rst)))
        else $error("sequence start not tied to slot register write");
    a_cal_busy_run: assert property (calRequest |=> calBusy)
        else $error("calibration busy did not hold");
    a_cal_ends_bounded: assert property (
        calRequest |-> ##[2:CalMax] !calRunning)
        else $error("calibration did not finish in time");
    a_sample_latency: assert property (convValid |-> ##2 sampleValid)
        else $error("sample did not follow conversion");
    // The tag is chosen from the code change seen at the converter edge
    // and from the enable as it stood one edge before the sample lands.
    a_tag_select: assert property (
        convValid && seen_q |-> ##2 sampleOut.tag ==
        (($past(tagEn_q) && $past(convDac, 2) != $past(lastDac_q, 2)) ?
        TagDacChange : 5'(TagNormal)))
        else $error("sample tag wrong");
    a_raw_passthrough: assert property (
        convValid && !filtEn_q |-> ##2 sampleOut.data == $past(rawNow, 2))
        else $error("unfiltered sample not raw result");
    a_presence_rate: assert property (
        presenceMode |-> activeRate == RateProximity)
        else $error("presence rate code wrong");
    a_lowpower_skip: assert property (
        lowPowerMode == presenceMode && slotSkipMask == presenceMode)
        else $error("low power or slot skip not following presence");
endmodule : osc_sample_conditioning_properties
bind osc_sample_conditioning osc_sample_conditioning_properties #(
    .CalLength(CalLength)) chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .convValid(convValid), .convAdc(convAdc),
    .convDac(convDac), .sampleValid(sampleValid), .sampleOut(sampleOut),
    .presenceMode(presenceMode), .activeRate(activeRate),
    .lowPowerMode(lowPowerMode), .slotSkipMask(slotSkipMask),
    .sequenceStart(sequenceStart), .calRunning(calRunning));
`default_nettype wire

/* File: tb/optical_sample_conditioning_test.sv */
// Self-checking bench for the sample-conditioning block.
`default_nettype none
module optical_sample_conditioning_test
    import osc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, regWr, regRd, convValid, convOnPdOne, extMuxUsed;
    logic calOutOfRangeIn, sampleValid, presenceMode, lowPowerMode;
    logic slotSkipMask, sequenceStart, calRunning;
    logic [7:0]  regAddr, regWdata, regRdata, slotLedCurrent;
    logic [15:0] convAdc;
    logic [4:0]  convDac, activeRate;
    logic [3:0]  convSlot;
    osc_sample_t sampleOut;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] rwRegs [9] = '{AddrIntEn2, AddrSyncTag, AddrConvSetup1,
        AddrConvSetup2, AddrPresThresh, AddrFilterCfg, AddrPresLed,
        AddrSlotSel12, AddrNormLed};
    // Short calibration keeps the run brief.
    osc_sample_conditioning #(.CalLength(10)) dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .convValid(convValid), .convAdc(convAdc), .convDac(convDac),
        .convSlot(convSlot), .convOnPdOne(convOnPdOne),
        .extMuxUsed(extMuxUsed), .calOutOfRangeIn(calOutOfRangeIn),
        .sampleValid(sampleValid), .sampleOut(sampleOut),
        .presenceMode(presenceMode), .slotLedCurrent(slotLedCurrent),
        .activeRate(activeRate), .lowPowerMode(lowPowerMode),
        .slotSkipMask(slotSkipMask), .sequenceStart(sequenceStart),
        .calRunning(calRunning));
    // Free-running 250 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), 32'(e), 32'(regRdata));
    endtask : rd
    // One conversion; the sample is looked at two edges later.
    task automatic conv(input logic [4:0] dac, input logic [15:0] adc,
                        input logic [18:0] ed, input logic [4:0] et);
        @(posedge ref_clk);
        convValid <= 1'b1;
        convAdc   <= adc;
        convDac   <= dac;
        @(posedge ref_clk);
        convValid <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("sampleValid", 32'h1, 32'(sampleValid));
        chk("sample data", 32'(ed), 32'(sampleOut.data));
        chk("sample tag", 32'(et), 32'(sampleOut.tag));
    endtask : conv
    task automatic presence(input logic p, input logic [7:0] led,
                            input logic [4:0] rate);
        chk("presenceMode", 32'(p), 32'(presenceMode));
        chk("lowPowerMode", 32'(p), 32'(lowPowerMode));
        chk("slotSkipMask", 32'(p), 32'(slotSkipMask));
        chk("slotLedCurrent", 32'(led), 32'(slotLedCurrent));
        chk("activeRate", 32'(rate), 32'(activeRate));
    endtask : presence
    // A hang counts as a mismatch and closes the run.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        {sys_rst, regWr, regRd, convValid, extMuxUsed} = 5'h10;
        {regAddr, regWdata, convAdc, convDac} = '0;
        {convSlot, convOnPdOne, calOutOfRangeIn} = 6'h07;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (rwRegs[i]) rd(rwRegs[i], 8'h00);
        foreach (rwRegs[i]) begin
            wr(rwRegs[i], 8'h5a);
            rd(rwRegs[i], 8'h5a);
            wr(rwRegs[i], 8'h00);
        end
        wr(8'hff, 8'hff);
        rd(8'hff, 8'h00);
        wr(AddrIntFlags2, 8'hff);
        rd(AddrIntFlags2, 8'h00);
        wr(AddrConvSetup1, 8'h0e);
        wr(AddrCalCtrl, 8'h01);
        #1;
        chk("calRunning", 32'h1, 32'(calRunning));
        // Poll off the edge so the flag is read once it has settled.
        for (int k = 0; k < 100 && calRunning; k++) begin
            @(posedge ref_clk) #1;
        end
        rd(AddrCalCtrl, 8'h06);
        wr(AddrSlotSel12, 8'h01);
        #1;
        chk("sequenceStart", 32'h1, 32'(sequenceStart));
        conv(5'h00, 16'h1234, 19'h01234, 5'(TagNormal));
        wr(AddrSyncTag, 8'h10);
        conv(5'h03, 16'h0010, 19'h0c010, TagDacChange);
        conv(5'h03, 16'h0011, 19'h0c011, 5'(TagNormal));
        wr(AddrSyncTag, 8'h00);
        wr(AddrNormLed, 8'h40);
        wr(AddrConvSetup2, 8'h28);
        wr(AddrPresLed, 8'h05);
        wr(AddrPresThresh, 8'h02);
        wr(AddrIntEn2, 8'h10);
        @(posedge ref_clk) extMuxUsed <= 1'b1;
        conv(5'h00, 16'd100, 19'd100, 5'(TagNormal));
        presence(1'b0, 8'h40, 5'h05);
        @(posedge ref_clk) {extMuxUsed, convOnPdOne} <= 2'b00;
        conv(5'h00, 16'd100, 19'd100, 5'(TagNormal));
        presence(1'b0, 8'h40, 5'h05);
        @(posedge ref_clk) {convOnPdOne, convSlot} <= 5'h12;
        conv(5'h00, 16'd100, 19'd100, 5'(TagNormal));
        presence(1'b0, 8'h40, 5'h05);
        @(posedge ref_clk) convSlot <= 4'h1;
        conv(5'h00, 16'd4095, 19'd4095, 5'(TagNormal));
        presence(1'b1, 8'h05, RateProximity);
        rd(AddrIntFlags2, 8'h10);
        rd(AddrIntFlags2, 8'h00);
        conv(5'h00, 16'd4096, 19'd4096, 5'(TagNormal));
        presence(1'b0, 8'h40, 5'h05);
        rd(AddrIntFlags2, 8'h10);
        wr(AddrIntEn2, 8'h00);
        wr(AddrFilterCfg, 8'h8f);
        repeat (4) conv(5'h00, 16'd1000, 19'd1000, 5'(TagNormal));
        conv(5'h00, 16'hffff, 19'd1000, 5'(TagNormal));
        wr(AddrFilterCfg, 8'h00);
        wr(AddrFilterCfg, 8'hcc);
        for (int k = 0; k < 5; k++) begin
            conv(5'h00, 16'(1000 + 100 * k), 19'(1000 + 100 * k),
                 5'(TagNormal));
        end
        conv(5'h00, 16'd30000, 19'd1500, 5'(TagNormal));
        summarize();
    end
endmodule : optical_sample_conditioning_test
`default_nettype wire
